// File: hw/fcct_top.sv
// Purpose: four channel 8-bit counter timer with daisy-chained vectored interrupts
// Assumes: all inputs synchronous to aclk; AXI4-Lite master keeps one access of each kind open
// Notes: the vector is driven only while the acknowledge cycle that claimed it lasts
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module fcct_top
    import fcct_pkg::*;
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address, data and response
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // host processor bus
    input  wire fcct_hbus_t           host_bus,
    output logic [7:0]                vector_data_out,
    output logic                      vector_data_oe,
    // channel pins
    input  wire logic [NUM_CH-1:0]    ext_clock_trigger,
    output logic [NUM_ZC-1:0]         zero_count_pulse_out,
    // interrupt chain
    output logic                      int_req_n,
    input  wire logic                 chain_enable_in,
    output logic                      chain_enable_out
);
    // every register below moves only on aclk, so a stopped clock freezes all of it

    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_held;
    logic [7:0]          w_byte;
    logic                w_lane0;
    logic                wr_go;
    logic                wr_mapped;
    logic                wr_fire;
    logic [1:0]          wr_ch;
    fcct_ctl_t           wctl;
    logic                rd_mapped;

    fcct_ctl_t           ctl       [NUM_CH];
    logic [7:0]          tc        [NUM_CH];
    logic [7:0]          cnt       [NUM_CH];
    logic [7:0]          pre       [NUM_CH];
    fcct_state_t         state     [NUM_CH];
    logic [NUM_CH-1:0]   trig_prev;
    logic [NUM_CH-1:0]   tc_next;
    logic [NUM_CH-1:0]   edge_hit;
    logic [NUM_CH-1:0]   pre_tick;
    logic [NUM_CH-1:0]   dec;
    logic [NUM_CH-1:0]   zero_evt;
    logic [NUM_CH-1:0]   wr_here;
    logic [NUM_CH-1:0]   tc_wr;
    logic [NUM_CH-1:0]   ctl_wr;
    logic [NUM_CH-1:0]   start_load;
    logic [NUM_CH-1:0]   ie_vec;

    logic [NUM_CH-1:0]   pending;
    logic [NUM_CH-1:0]   in_service;
    logic [NUM_CH-1:0]   grant;
    logic [NUM_CH-1:0]   return_from_interrupt_instr_sel;
    logic [NUM_CH-1:0]   return_from_interrupt_instr_clr;
    logic [1:0]          grant_idx;
    logic                req_any;
    logic [4:0]          vec_hi;
    logic                ack_lvl;
    logic                ack_prev;
    logic                ack_take;
    logic                ack_owner;
    logic                fetch_lvl;
    logic                fetch_prev;
    logic [7:0]          fetch_byte;
    logic [7:0]          last_op;
    logic                return_from_interrupt_instr_hit;

    // axi4-lite write side: address and data taken in either order, answered once both are in
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign wr_go         = aw_held & w_held & ~s_axi_bvalid;
    assign wr_mapped     = (aw_addr[ADDR_W-1:MAP_TOP_LSB] == '0);
    // a write without byte lane 0 carries nothing for an 8-bit register, so it is dropped
    assign wr_fire       = wr_go & wr_mapped & w_lane0;
    assign wr_ch         = aw_addr[CH_SEL_LSB+1:CH_SEL_LSB];
    assign wctl          = fcct_ctl_t'(w_byte);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read side: every channel offset returns its live down-counter
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_mapped     = (s_axi_araddr[ADDR_W-1:MAP_TOP_LSB] == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mapped ? {24'h00_0000, cnt[s_axi_araddr[CH_SEL_LSB+1:CH_SEL_LSB]]}
                                      : 32'h0000_0000;
            s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [7:0] mask;

        assign wr_here[i]    = wr_fire && (wr_ch == 2'(i));
        // the write right after a control word that announces it is the time constant
        assign tc_wr[i]      = wr_here[i] & tc_next[i];
        assign ctl_wr[i]     = wr_here[i] & ~tc_next[i] & w_byte[0];
        assign start_load[i] = tc_wr[i] && (state[i] == ST_STOP);
        assign ie_vec[i]     = ctl[i].ie;
        assign edge_hit[i]   = ctl[i].rising ? (ext_clock_trigger[i] & ~trig_prev[i])
                                             : (~ext_clock_trigger[i] & trig_prev[i]);
        assign mask          = ctl[i].pre256 ? PRE_MASK_256 : PRE_MASK_16;
        assign pre_tick[i]   = (state[i] == ST_RUN) && !ctl[i].counter_mode && ((pre[i] & mask) == mask);
        assign dec[i]        = (state[i] == ST_RUN) && (ctl[i].counter_mode ? edge_hit[i] : pre_tick[i]);
        // 00H wraps to FFH on the first step, so it runs 256 steps before the next zero
        assign zero_evt[i]   = dec[i] && (cnt[i] == CNT_LAST);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                trig_prev[i] <= 1'b0;
            end else begin
                trig_prev[i] <= ext_clock_trigger[i];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctl[i]     <= CTL_RESET;
                tc_next[i] <= 1'b0;
            end else if (ctl_wr[i]) begin
                ctl[i]     <= wctl;
                tc_next[i] <= wctl.tc_follows;
            end else if (tc_wr[i]) begin
                tc_next[i] <= 1'b0;
            end
        end

        // a new constant written while running takes effect at the next zero
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                tc[i] <= TC_RESET;
            end else if (tc_wr[i]) begin
                tc[i] <= w_byte;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                state[i] <= ST_STOP;
            end else if (ctl_wr[i] && wctl.soft_rst) begin
                state[i] <= ST_STOP;
            end else begin
                case (state[i])
                    ST_STOP: begin
                        if (start_load[i]) begin
                            state[i] <= (!ctl[i].counter_mode && ctl[i].ext_trig) ? ST_ARM : ST_RUN;
                        end
                    end
                    ST_ARM: begin
                        if (edge_hit[i]) begin
                            state[i] <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        state[i] <= ST_RUN;
                    end
                    default: begin
                        state[i] <= ST_STOP;
                    end
                endcase
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt[i] <= CNT_RESET;
            end else if (start_load[i]) begin
                cnt[i] <= w_byte;
            end else if (zero_evt[i]) begin
                cnt[i] <= tc[i];
            end else if (dec[i]) begin
                cnt[i] <= 8'(cnt[i] - 8'h01);
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pre[i] <= PRE_RESET;
            end else if (state[i] != ST_RUN) begin
                pre[i] <= PRE_RESET;
            end else if (!ctl[i].counter_mode) begin
                pre[i] <= 8'(pre[i] + 8'h01);
            end
        end

        if (i < NUM_ZC) begin : g_zc
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    zero_count_pulse_out[i] <= 1'b0;
                end else begin
                    zero_count_pulse_out[i] <= zero_evt[i];
                end
            end
        end
    end

    // daisy chain inside the device, channel 0 nearest the head
    always_comb begin
        logic ok;
        logic found;
        logic rfound;
        ok        = chain_enable_in;
        found     = 1'b0;
        rfound    = 1'b0;
        grant     = '0;
        return_from_interrupt_instr_sel  = '0;
        req_any   = 1'b0;
        grant_idx = 2'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (ok && pending[i] && !found) begin
                grant[i]  = 1'b1;
                grant_idx = 2'(i);
                found     = 1'b1;
            end
            if (in_service[i] && !rfound) begin
                return_from_interrupt_instr_sel[i] = 1'b1;
                rfound      = 1'b1;
            end
            req_any = req_any | (ok & pending[i]);
            ok      = ok & ~in_service[i];
        end
    end

    assign int_req_n        = ~req_any;
    // a pending request also holds lower devices off so they cannot outrun it
    assign chain_enable_out = chain_enable_in & ~(|in_service) & ~(|pending);

    // only the mode 2 acknowledge is answered: a vector, never an opcode
    assign ack_lvl  = ~host_bus.machine_cycle_one_n & ~host_bus.io_request_n;
    assign ack_take = ack_lvl & ~ack_prev & (|grant);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_hi <= VEC_RESET;
        end else if (wr_here[0] && !tc_next[0] && !w_byte[0]) begin
            vec_hi <= w_byte[7:3];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_prev        <= 1'b0;
            ack_owner       <= 1'b0;
            vector_data_out <= 8'h00;
        end else begin
            ack_prev <= ack_lvl;
            if (ack_take) begin
                ack_owner       <= 1'b1;
                vector_data_out <= {vec_hi, grant_idx, 1'b0};
            end else if (!ack_lvl) begin
                ack_owner <= 1'b0;
            end
        end
    end

    assign vector_data_oe = ack_lvl & ack_owner;

    // a new zero in the acknowledge cycle wins over the clear, so no request is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~(ack_take ? grant : '0) & ie_vec) | (zero_evt & ie_vec);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_service <= '0;
        end else begin
            in_service <= (in_service | (ack_take ? grant : '0)) & ~return_from_interrupt_instr_clr;
        end
    end

    // opcode fetches are watched; the byte seen last in a fetch is its opcode
    assign fetch_lvl = ~host_bus.machine_cycle_one_n & ~host_bus.read_n & host_bus.io_request_n;
    assign return_from_interrupt_instr_hit  = fetch_prev & ~fetch_lvl & (last_op == RETURN_FROM_INTERRUPT_INSTR_OP1) & (fetch_byte == RETURN_FROM_INTERRUPT_INSTR_OP2) & chain_enable_in;
    assign return_from_interrupt_instr_clr  = return_from_interrupt_instr_hit ? return_from_interrupt_instr_sel : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_prev <= 1'b0;
            fetch_byte <= 8'h00;
            last_op    <= 8'h00;
        end else begin
            fetch_prev <= fetch_lvl;
            if (fetch_lvl) begin
                fetch_byte <= host_bus.data;
            end
            if (fetch_prev && !fetch_lvl) begin
                last_op <= fetch_byte;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_zero_reload: assert property (zero_evt[0] |=> cnt[0] == $past(tc[0]))
        else $error("counter not reloaded at zero");
    a_zc_pulse_one: assert property (zero_evt[1] |=> zero_count_pulse_out[1] ##1 !zero_count_pulse_out[1])
        else $error("zero-count pulse wrong");
    a_timer_step: assert property (dec[0] && cnt[0] != CNT_LAST |=> cnt[0] == 8'($past(cnt[0]) - 8'h01))
        else $error("counter did not step by one");
    a_prescale_gap: assert property (pre_tick[0] |=> !pre_tick[0] [*8])
        else $error("prescaler tick too soon");
    a_int_cause: assert property (!int_req_n |-> chain_enable_in && (pending != '0))
        else $error("request without cause");
    a_int_raise: assert property (zero_evt[3] && ctl[3].ie && chain_enable_in && in_service == '0
                                  |=> !int_req_n)
        else $error("zero with enable gave no request");
    a_chain_out: assert property (chain_enable_out |-> chain_enable_in && in_service == '0)
        else $error("chain out high while serviced");
    a_ack_vector: assert property (ack_take |=> vector_data_out[2:0] == {$past(grant_idx), 1'b0}
                                   && vector_data_oe == ack_lvl)
        else $error("vector wrong after acknowledge");
    a_return_from_interrupt_instr_clear: assert property (return_from_interrupt_instr_hit && in_service != '0 && !ack_take
                                   |=> $countones(in_service) == $countones($past(in_service)) - 1)
        else $error("return did not end service");
    a_tc_load: assert property (start_load[2] |=> cnt[2] == $past(w_byte) && state[2] != ST_STOP)
        else $error("counter not loaded at start");
    a_reset_stop: assert property (@(posedge aclk) disable iff (1'b0)
                                   !aresetn |=> state[1] == ST_STOP && !ctl[1].ie && pending == '0)
        else $error("reset did not stop channel");

    c_zero_ch3: cover property (zero_evt[3]);
    c_ack: cover property (ack_take ##[1:20] vector_data_oe);
    c_return_from_interrupt_instr: cover property (return_from_interrupt_instr_hit && in_service != '0);
    c_counter_mode: cover property (dec[1] && ctl[1].counter_mode);
endmodule

// File: hw/fcct_pkg.sv
// Purpose: constants, types and layouts shared by the four channel counter timer
// Assumes: one 20 MHz clock, AXI4-Lite register access, 8-bit host data bus for acknowledge
// Notes: control word layout is fixed by fcct_ctl_t below
package fcct_pkg;
    localparam int          NUM_CH          = 4;
    localparam int          NUM_ZC          = 3;
    localparam int          ADDR_W          = 8;
    localparam int          CH_SEL_LSB      = 2;
    localparam int          MAP_TOP_LSB     = 4;
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          RESET_HOLD_CLKS = 3;
    localparam logic [7:0]  TC_RESET        = 8'h00;
    localparam logic [7:0]  CNT_RESET       = 8'h00;
    localparam logic [7:0]  PRE_RESET       = 8'h00;
    localparam logic [4:0]  VEC_RESET       = 5'h00;
    localparam logic [7:0]  PRE_MASK_16     = 8'h0F;
    localparam logic [7:0]  PRE_MASK_256    = 8'hFF;
    localparam logic [7:0]  CNT_LAST        = 8'h01;
    localparam logic [7:0]  RETURN_FROM_INTERRUPT_INSTR_OP1        = 8'hED;
    localparam logic [7:0]  RETURN_FROM_INTERRUPT_INSTR_OP2        = 8'h4D;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // control word, bit 7 down to bit 0
    typedef struct packed {
        logic ie;
        logic counter_mode;
        logic pre256;
        logic rising;
        logic ext_trig;
        logic tc_follows;
        logic soft_rst;
        logic is_ctrl;
    } fcct_ctl_t;

    localparam fcct_ctl_t CTL_RESET = 8'h00;

    // host processor pins watched for acknowledge and opcode fetch
    typedef struct packed {
        logic       machine_cycle_one_n;
        logic       io_request_n;
        logic       read_n;
        logic [7:0] data;
    } fcct_hbus_t;

    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } fcct_state_t;
endpackage

// File: verification/fcct_host_model.sv
// Purpose: host processor side of the vectored interrupt bus
// Assumes: acknowledge and opcode fetches span whole clock cycles
// Notes: released data lines show a pattern that changes every cycle
`timescale 1ns/1ps
module fcct_host_model
    import fcct_pkg::*;
(
    // clock
    input  wire logic       aclk,
    // device vector drive
    input  wire logic [7:0] vector_data_out,
    input  wire logic       vector_data_oe,
    // processor pins
    output fcct_hbus_t      host_bus
);
    logic       m1_n    = 1'b1;
    logic       io_request_n_n  = 1'b1;
    logic       rd_n    = 1'b1;
    logic       drive   = 1'b0;
    logic [7:0] fetch_b = 8'h00;
    logic [7:0] idle_b  = 8'h5A;
    // a stale byte on the released bus must never pass for a vector
    always @(posedge aclk) idle_b <= idle_b + 8'h3B;
    assign host_bus = {m1_n, io_request_n_n, rd_n, vector_data_oe ? vector_data_out : (drive ? fetch_b : idle_b)};
    // mode 2 acknowledge: vector taken while both strobes still stand
    task automatic ack(output logic [7:0] vec);
        m1_n   <= 1'b0;
        io_request_n_n <= 1'b0;
        repeat (3) @(posedge aclk);
        vec = host_bus.data;
        m1_n   <= 1'b1;
        io_request_n_n <= 1'b1;
        @(posedge aclk);
    endtask
    task automatic fetch(input logic [7:0] b);
        m1_n    <= 1'b0;
        rd_n    <= 1'b0;
        drive   <= 1'b1;
        fetch_b <= b;
        repeat (2) @(posedge aclk);
        m1_n    <= 1'b1;
        rd_n    <= 1'b1;
        drive   <= 1'b0;
        @(posedge aclk);
    endtask
    // two opcode fetches in a row end the service routine
    task automatic return_from_interrupt_instr();
        fetch(RETURN_FROM_INTERRUPT_INSTR_OP1);
        fetch(RETURN_FROM_INTERRUPT_INSTR_OP2);
        repeat (2) @(posedge aclk);
    endtask
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for the four channel counter timer
// Assumes: registers at 0x0/0x4/0x8/0xC, control layout of fcct_ctl_t
// Notes: random time constant for channel 1 from a fixed seed; timer periods measured on pulse 0
`timescale 1ns/1ps
module tb;
    import fcct_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, vec_oe, int_req_n, ch_out, ch_in = 1'b1;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  trig = 4'h0;
    logic [3:0]  strb = 4'hF;
    logic [2:0]  zc;
    logic [7:0]  vec_out, d, v, tc;
    fcct_hbus_t  host_bus;
    int          failures = 0, cmp_count = 0, zc_n[3] = '{0, 0, 0}, n, i, p;
    always #25 aclk = ~aclk;
    always @(posedge aclk) for (int k = 0; k < 3; k++) zc_n[k] += zc[k];
    fcct_top u_fcct_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_bus(host_bus),
        .vector_data_out(vec_out), .vector_data_oe(vec_oe), .ext_clock_trigger(trig),
        .zero_count_pulse_out(zc), .int_req_n(int_req_n), .chain_enable_in(ch_in), .chain_enable_out(ch_out));
    fcct_host_model u_host (.aclk(aclk), .vector_data_out(vec_out), .vector_data_oe(vec_oe), .host_bus(host_bus));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // zero pulse spacing of a timer: prescale times time constant, 0 meaning 256
    function automatic int exp_period(input int pre_div, input int tcv);
        return pre_div * (tcv == 0 ? 256 : tcv);
    endfunction
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] dv, output logic [1:0] rs);
        int k;
        k = 0;
        awaddr <= a; wdata <= {24'h0, dv}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && k < 100);
        rs = bresp;
        // bready stays high, so a next call never lowers and raises it in one step
        if (k >= 100) begin failures++; give_verdict(); end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dv, output logic [1:0] rs);
        int k;
        k = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && k < 100);
        dv = rdata[7:0];
        rs = rresp;
        if (k >= 100) begin failures++; give_verdict(); end
    endtask
    task automatic edges(input int cnt);
        repeat (cnt) begin
            trig[1] <= 1'b1; repeat (2) @(posedge aclk);
            trig[1] <= 1'b0; repeat (2) @(posedge aclk);
        end
    endtask
    // distance in cycles between two successive zero pulses of channel 0
    task automatic period(output int pr);
        int k;
        k = 0;
        while (!zc[0] && k < 5000) begin @(posedge aclk); k++; end
        if (k >= 5000) begin failures++; give_verdict(); end
        pr = 0;
        @(posedge aclk);
        while (!zc[0] && pr < 5000) begin @(posedge aclk); pr++; end
        if (pr >= 5000) begin failures++; give_verdict(); end
        pr++;
    endtask
    initial begin
        void'($urandom(86232));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 4; i++) begin rd(8'(i * 4), d, r); chk("cnt_after_reset", 0, d); end
        chk("irq_idle", 1, int_req_n);
        rd(8'h40, d, r); chk("rresp_unmapped", RESP_SLVERR, r);
        wr(8'h40, 8'hD5, r); chk("bresp_unmapped", RESP_SLVERR, r);
        wr(8'h00, 8'hA8, r); // vector high bits via channel 0
        tc = 8'($urandom_range(2, 200));
        n = $urandom_range(1, tc - 1);
        wr(8'h04, 8'hD5, r); wr(8'h04, tc, r);
        rd(8'h04, d, r); chk("cnt_loaded", tc, d);
        edges(n);
        rd(8'h04, d, r); chk("cnt_counted", tc - 8'(n), d);
        edges(tc - n);
        chk("zero_pulse_ch1", 1, zc_n[1]);
        rd(8'h04, d, r); chk("cnt_reloaded", tc, d);
        chk("irq_low", 0, int_req_n);
        chk("chain_out_pending", 0, ch_out);
        u_host.ack(v); chk("vec_ch1", 8'hAA, v);
        chk("chain_out_service", 0, ch_out);
        u_host.return_from_interrupt_instr(); chk("chain_out_after_return_from_interrupt_instr", 1, ch_out);
        // a write without byte lane 0 must not stop the running channel
        strb <= 4'hE; wr(8'h04, 8'h03, r); chk("bresp_no_lane", RESP_OKAY, r);
        strb <= 4'hF; edges(1);
        rd(8'h04, d, r); chk("cnt_lane_ignored", tc - 8'h01, d);
        // all four at once, two on rising and two on falling edges
        trig <= 4'b1100;
        for (i = 0; i < 4; i++) begin
            wr(8'(i * 4), 8'h03, r);
            wr(8'(i * 4), i > 1 ? 8'hC5 : 8'hD5, r);
            wr(8'(i * 4), 8'h01, r);
        end
        trig <= 4'b0011;
        repeat (3) @(posedge aclk);
        for (i = 0; i < 3; i++) chk("zero_pulse_all", i == 1 ? 2 : 1, zc_n[i]);
        ch_in <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("irq_chain_low", 1, int_req_n);
        chk("chain_out_in_low", 0, ch_out);
        ch_in <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 4; i++) begin
            u_host.ack(v); chk("vec_priority", {5'h15, i[1:0], 1'b0}, v);
            u_host.return_from_interrupt_instr();
        end
        chk("irq_all_served", 1, int_req_n);
        // timer on channel 3 waits in arm until a rising trigger edge
        wr(8'h0C, 8'h03, r); wr(8'h0C, 8'h1D, r); wr(8'h0C, 8'h02, r);
        repeat (40) @(posedge aclk);
        rd(8'h0C, d, r); chk("cnt_armed", 2, d);
        trig[3] <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(8'h0C, d, r); chk("cnt_triggered", 1, d);
        // timer periods: prescale times time constant, 00 meaning 256
        for (i = 0; i < 3; i++) begin
            wr(8'h00, 8'h03, r);
            wr(8'h00, i == 1 ? 8'h25 : 8'h05, r);
            wr(8'h00, i == 0 ? 8'h03 : 8'h00 + 8'(i == 1), r);
            period(p); chk("timer_period", exp_period(i == 1 ? 256 : 16, i == 0 ? 3 : (i == 1 ? 1 : 0)), p);
        end
        give_verdict();
    end
endmodule
